// >>> scg_gate_reg.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Gate enable register with write mask
// ****************************************************************
module scg_gate_reg
	import scg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wr,
	input wire logic [31:0] wdata,
	output var logic [31:0] value_ff
);
	logic [31:0] nxt_value;

	// Only writable bits take write data
	always_comb
	begin
		nxt_value = value_ff;
		if (wr)
			nxt_value = wdata & SCG_WR_MASK;
	end

	// Reset clears all enables
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			value_ff <= SCG_GATE_RESET;
		else if (ce)
			value_ff <= nxt_value;
	end
endmodule
`default_nettype wire

// >>> scg_pkg.sv
package scg_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] SCG_OFF_SLEEP_GATE = 12'h118;
	localparam logic [11:0] SCG_OFF_IRQ_STATUS = 12'h200;
	localparam logic [11:0] SCG_OFF_IRQ_ENABLE = 12'h204;
	localparam logic [11:0] SCG_OFF_IRQ_CLEAR = 12'h208;
	localparam logic [11:0] SCG_OFF_MODE_CTRL = 12'h20C;
	// ****************************************************************
	// Field layout and reset values
	// ****************************************************************
	localparam int SCG_BIT_PHY = 30;
	localparam int SCG_BIT_MAC = 28;
	localparam int SCG_NUM_PORTS = 8;
	localparam logic [31:0] SCG_WR_MASK = 32'h500000FF;
	localparam logic [31:0] SCG_GATE_RESET = 32'h00000000;
	localparam int SCG_NUM_UNITS = 10;
	localparam logic [9:0] SCG_UNITS_RESET = 10'h000;
	// Mode control field positions
	localparam int SCG_BIT_AUTO_GATE = 0;
	localparam int SCG_BIT_SLEEP = 1;
	// Interrupt status positions
	localparam int SCG_EV_FAULT = 0;
	localparam int SCG_EV_GATE_WR = 1;
	localparam int SCG_NUM_EV = 2;
endpackage

// >>> scg_sleep_gate.sv
// Summary of operation
// - One clocks unit in sleep, zero gates it
// - Access to gated unit answers bus fault
// - Register resets to all zeros
// - Register at 0x118, sleep mode only
// - Applied only when auto gating enabled
// - Bit 30 enables ethernet phy clock
// - Bit 28 enables ethernet mac clock
// - Bits 7..0 enable ports H..A
// - Bits 31, 29, 27:8 read zero
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module scg_sleep_gate
	import scg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [SCG_NUM_UNITS-1:0] unit_access,
	output logic [SCG_NUM_UNITS-1:0] unit_fault,
	output logic ethernet_phy_clock_enable,
	output logic ethernet_mac_clock_enable,
	output logic [SCG_NUM_PORTS-1:0] port_clock_enable,
	output logic irq
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [31:0] rdata;
		logic slverr;
		logic ready;
		logic auto_gate;
		logic sleep;
		logic [SCG_NUM_EV-1:0] status;
		logic [SCG_NUM_EV-1:0] enable;
		logic [SCG_NUM_UNITS-1:0] clk_en;
		logic [SCG_NUM_UNITS-1:0] fault;
		logic irq;
	} scg_state_t;

	scg_state_t st_ff;
	scg_state_t nxt_st;
	logic [31:0] gate_value;
	logic gate_wr;
	logic bus_done;
	logic [SCG_NUM_UNITS-1:0] units_cfg;
	logic [SCG_NUM_UNITS-1:0] units_eff;
	logic addr_mapped;

	// APB answers in the access phase, no wait states
	assign bus_done = psel && penable;
	assign gate_wr = bus_done && pwrite && (paddr == SCG_OFF_SLEEP_GATE);
	// Address hits one of the mapped registers
	assign addr_mapped = (paddr == SCG_OFF_SLEEP_GATE) || (paddr == SCG_OFF_IRQ_STATUS)
		|| (paddr == SCG_OFF_IRQ_ENABLE) || (paddr == SCG_OFF_IRQ_CLEAR)
		|| (paddr == SCG_OFF_MODE_CTRL);

	scg_gate_reg u_gate
	(
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.wr(gate_wr),
		.wdata(pwdata),
		.value_ff(gate_value)
	);

	// ****************************************************************
	// Per-unit enables
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < SCG_NUM_PORTS; gi++)
		begin : g_port
			assign units_cfg[gi] = gate_value[gi];
		end
	endgenerate
	assign units_cfg[SCG_NUM_PORTS] = gate_value[SCG_BIT_MAC];
	assign units_cfg[SCG_NUM_PORTS+1] = gate_value[SCG_BIT_PHY];

	// Sleep value used only in sleep with auto gating; else all clocked
	always_comb
	begin
		if (st_ff.sleep && st_ff.auto_gate)
			units_eff = units_cfg;
		else
			units_eff = {SCG_NUM_UNITS{1'b1}};
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic [SCG_NUM_EV-1:0] ev;
		logic [SCG_NUM_EV-1:0] clr;
		ev = '0;
		clr = '0;
		nxt_st = st_ff;
		nxt_st.slverr = 1'b0;
		nxt_st.ready = 1'b1; // No wait states
		nxt_st.clk_en = units_eff;
		// Fault for any access to an unclocked unit
		nxt_st.fault = unit_access & ~units_eff;
		ev[SCG_EV_FAULT] = |(unit_access & ~units_eff);
		ev[SCG_EV_GATE_WR] = gate_wr;
		if (psel && !penable)
		begin
			nxt_st.rdata = 32'h00000000;
			if (!pwrite)
			begin
				unique case (paddr)
					SCG_OFF_SLEEP_GATE: nxt_st.rdata = gate_value & SCG_WR_MASK;
					SCG_OFF_IRQ_STATUS: nxt_st.rdata[SCG_NUM_EV-1:0] = st_ff.status;
					SCG_OFF_IRQ_ENABLE: nxt_st.rdata[SCG_NUM_EV-1:0] = st_ff.enable;
					SCG_OFF_MODE_CTRL:
					begin
						nxt_st.rdata[SCG_BIT_AUTO_GATE] = st_ff.auto_gate;
						nxt_st.rdata[SCG_BIT_SLEEP] = st_ff.sleep;
					end
					SCG_OFF_IRQ_CLEAR: nxt_st.rdata = 32'h00000000;
					default: nxt_st.slverr = 1'b1;
				endcase
			end
			else
			begin
				unique case (paddr)
					SCG_OFF_SLEEP_GATE, SCG_OFF_IRQ_ENABLE,
					SCG_OFF_IRQ_CLEAR, SCG_OFF_MODE_CTRL,
					SCG_OFF_IRQ_STATUS: nxt_st.slverr = 1'b0;
					default: nxt_st.slverr = 1'b1;
				endcase
			end
		end
		else if (bus_done)
		begin
			nxt_st.slverr = st_ff.slverr;
			if (pwrite)
			begin
				if (paddr == SCG_OFF_IRQ_ENABLE)
					nxt_st.enable = pwdata[SCG_NUM_EV-1:0];
				if (paddr == SCG_OFF_IRQ_CLEAR)
					clr = pwdata[SCG_NUM_EV-1:0];
				if (paddr == SCG_OFF_MODE_CTRL)
				begin
					nxt_st.auto_gate = pwdata[SCG_BIT_AUTO_GATE];
					nxt_st.sleep = pwdata[SCG_BIT_SLEEP];
				end
			end
		end
		// New event wins over clear
		nxt_st.status = (st_ff.status & ~clr) | ev;
		nxt_st.irq = |(nxt_st.status & nxt_st.enable);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_ff <= '0;
			st_ff.clk_en <= {SCG_NUM_UNITS{1'b1}};
			st_ff.ready <= 1'b1;
		end
		else if (ce)
			st_ff <= nxt_st;
	end

	// Outputs straight from flops
	assign prdata = st_ff.rdata;
	assign pslverr = st_ff.slverr;
	assign pready = st_ff.ready;
	assign unit_fault = st_ff.fault;
	assign port_clock_enable = st_ff.clk_en[SCG_NUM_PORTS-1:0];
	assign ethernet_mac_clock_enable = st_ff.clk_en[SCG_NUM_PORTS];
	assign ethernet_phy_clock_enable = st_ff.clk_en[SCG_NUM_PORTS+1];
	assign irq = st_ff.irq;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_gated_in_sleep;
		@(posedge clk) disable iff (!nrst)
		(ce && st_ff.sleep && st_ff.auto_gate) |=> (st_ff.clk_en == $past(units_cfg));
	endproperty
	a_gated_in_sleep: assert property (p_gated_in_sleep) else $error("sleep enables wrong");

	property p_fault;
		@(posedge clk) disable iff (!nrst)
		(ce && |(unit_access & ~units_eff)) |=> (|unit_fault);
	endproperty
	a_fault: assert property (p_fault) else $error("no fault on gated access");

	property p_no_fault;
		@(posedge clk) disable iff (!nrst)
		(ce && (unit_access & ~units_eff) == '0) |=> (unit_fault == '0);
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("spurious fault");

	property p_reserved_zero;
		@(posedge clk) disable iff (!nrst)
		(gate_value & ~SCG_WR_MASK) == 32'h00000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_write_masked;
		@(posedge clk) disable iff (!nrst)
		(ce && gate_wr) |=> (gate_value == ($past(pwdata) & SCG_WR_MASK));
	endproperty
	a_write_masked: assert property (p_write_masked) else $error("gate write wrong");

	property p_awake_all_on;
		@(posedge clk) disable iff (!nrst)
		(ce && !(st_ff.sleep && st_ff.auto_gate)) |=> (&st_ff.clk_en);
	endproperty
	a_awake_all_on: assert property (p_awake_all_on) else $error("gated outside sleep");

	property p_phy_bit;
		@(posedge clk) disable iff (!nrst)
		(ce && st_ff.sleep && st_ff.auto_gate)
			|=> (ethernet_phy_clock_enable == $past(gate_value[SCG_BIT_PHY]));
	endproperty
	a_phy_bit: assert property (p_phy_bit) else $error("phy enable wrong");

	property p_mac_bit;
		@(posedge clk) disable iff (!nrst)
		(ce && st_ff.sleep && st_ff.auto_gate)
			|=> (ethernet_mac_clock_enable == $past(gate_value[SCG_BIT_MAC]));
	endproperty
	a_mac_bit: assert property (p_mac_bit) else $error("mac enable wrong");

	property p_irq;
		@(posedge clk) disable iff (!nrst)
		irq == |(st_ff.status & st_ff.enable);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_err_unmap;
		@(posedge clk) disable iff (!nrst)
		(ce && psel && !penable && !addr_mapped) |=> pslverr;
	endproperty
	a_err_unmap: assert property (p_err_unmap) else $error("unmapped address not refused");

	property p_err_map;
		@(posedge clk) disable iff (!nrst)
		(ce && psel && !penable && addr_mapped) |=> !pslverr;
	endproperty
	a_err_map: assert property (p_err_map) else $error("mapped address refused");

	property p_err_idle;
		@(posedge clk) disable iff (!nrst)
		(ce && !psel) |=> !pslverr;
	endproperty
	a_err_idle: assert property (p_err_idle) else $error("error while idle");

	property p_rd_gate;
		@(posedge clk) disable iff (!nrst)
		(ce && psel && !penable && !pwrite && paddr == SCG_OFF_SLEEP_GATE)
			|=> ((prdata & ~SCG_WR_MASK) == 32'h00000000) && (prdata == $past(gate_value));
	endproperty
	a_rd_gate: assert property (p_rd_gate) else $error("gate read wrong");

	property p_rd_hold;
		@(posedge clk) disable iff (!nrst)
		(ce && psel && penable) |=> $stable(prdata) && $stable(pslverr);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer moved");

	property p_gate_hold;
		@(posedge clk) disable iff (!nrst)
		!(ce && gate_wr) |=> $stable(gate_value);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gate changed unasked");

	property p_ev_fault;
		@(posedge clk) disable iff (!nrst)
		(ce && |(unit_access & ~units_eff)) |=> st_ff.status[SCG_EV_FAULT];
	endproperty
	a_ev_fault: assert property (p_ev_fault) else $error("fault not recorded");

	property p_ev_gate;
		@(posedge clk) disable iff (!nrst)
		(ce && gate_wr) |=> st_ff.status[SCG_EV_GATE_WR];
	endproperty
	a_ev_gate: assert property (p_ev_gate) else $error("gate write not recorded");

	property p_sticky;
		@(posedge clk) disable iff (!nrst)
		(ce && st_ff.status[SCG_EV_FAULT]
			&& !(bus_done && pwrite && paddr == SCG_OFF_IRQ_CLEAR && pwdata[SCG_EV_FAULT]))
			|=> st_ff.status[SCG_EV_FAULT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault status lost");

	property p_clear;
		@(posedge clk) disable iff (!nrst)
		(ce && bus_done && pwrite && paddr == SCG_OFF_IRQ_CLEAR && pwdata[SCG_EV_FAULT]
			&& !(|(unit_access & ~units_eff))) |=> !st_ff.status[SCG_EV_FAULT];
	endproperty
	a_clear: assert property (p_clear) else $error("fault status not cleared");

	property p_port_bits;
		@(posedge clk) disable iff (!nrst)
		(ce && st_ff.sleep && st_ff.auto_gate)
			|=> (port_clock_enable == $past(gate_value[SCG_NUM_PORTS-1:0]));
	endproperty
	a_port_bits: assert property (p_port_bits) else $error("port enables wrong");

	property p_mode_wr;
		@(posedge clk) disable iff (!nrst)
		(ce && bus_done && pwrite && paddr == SCG_OFF_MODE_CTRL)
			|=> (st_ff.auto_gate == $past(pwdata[SCG_BIT_AUTO_GATE]))
			&& (st_ff.sleep == $past(pwdata[SCG_BIT_SLEEP]));
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

	property p_en_wr;
		@(posedge clk) disable iff (!nrst)
		(ce && bus_done && pwrite && paddr == SCG_OFF_IRQ_ENABLE)
			|=> (st_ff.enable == $past(pwdata[SCG_NUM_EV-1:0]));
	endproperty
	a_en_wr: assert property (p_en_wr) else $error("enable write lost");

	property p_freeze;
		@(posedge clk) disable iff (!nrst)
		!ce |=> $stable(st_ff) && $stable(gate_value);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");

	c_fault: cover property (@(posedge clk) disable iff (!nrst) |unit_fault);
	c_gate_wr: cover property (@(posedge clk) disable iff (!nrst) gate_wr);
	c_irq: cover property (@(posedge clk) disable iff (!nrst) irq);
	c_sleep: cover property (@(posedge clk) disable iff (!nrst) st_ff.sleep && st_ff.auto_gate);
	c_refused: cover property (@(posedge clk) disable iff (!nrst) pslverr);
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import scg_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [9:0] unit_access = 10'h000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [9:0] unit_fault;
	logic phy_en;
	logic mac_en;
	logic [7:0] port_en;
	logic irq;
	logic [9:0] en;
	logic [31:0] r;
	logic e;
	logic [9:0] f;
	int fail_count = 0;
	int check_count = 0;
	// ****************************************************************
	// Device under test
	// ****************************************************************
	scg_sleep_gate i_scg_sleep_gate (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_access(unit_access),
		.unit_fault(unit_fault), .ethernet_phy_clock_enable(phy_en),
		.ethernet_mac_clock_enable(mac_en), .port_clock_enable(port_en), .irq(irq));
	// Unit enables as one vector, PHY on top
	assign en = {phy_en, mac_en, port_en};
	// 25 MHz clock
	always #20 clk = ~clk;
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16 && pready !== 1'b1)
		begin
			fail_count++;
			give_verdict();
		end
	endtask
	// Pulse one unit access and collect any fault
	task automatic poke(input int u);
		@(posedge clk);
		unit_access <= 10'h001 << u;
		f = 10'h000;
		repeat (4)
		begin
			@(posedge clk);
			f |= unit_fault;
			unit_access <= 10'h000;
		end
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
		chk("gate reset", r, 32'h00000000);
		chk("awake enables", {22'h0, en}, 32'h3FF);
		chk("irq reset", {31'h0, irq}, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_fields();
		apb(1'b1, SCG_OFF_SLEEP_GATE, 32'hFFFFFFFF);
		apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
		chk("all ones", r, 32'h500000FF);
		apb(1'b1, SCG_OFF_SLEEP_GATE, 32'hAFFFFF00);
		apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
		chk("reserved only", r, 32'h00000000);
		$display("test fields done");
	endtask
	task automatic t_gate();
		apb(1'b1, SCG_OFF_SLEEP_GATE, 32'h40000005);
		apb(1'b1, SCG_OFF_MODE_CTRL, 32'h3);
		repeat (3) @(posedge clk);
		chk("sleep gated", {22'h0, en}, 32'h205);
		apb(1'b1, SCG_OFF_MODE_CTRL, 32'h2);
		repeat (3) @(posedge clk);
		chk("no auto gating", {22'h0, en}, 32'h3FF);
		apb(1'b1, SCG_OFF_MODE_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk("not asleep", {22'h0, en}, 32'h3FF);
		apb(1'b1, SCG_OFF_MODE_CTRL, 32'h3);
		repeat (3) @(posedge clk);
		$display("test gate done");
	endtask
	task automatic t_fault();
		apb(1'b1, SCG_OFF_IRQ_ENABLE, 32'h1);
		poke(0);
		chk("clocked port", {22'h0, f}, 32'h0);
		poke(9);
		chk("clocked phy", {22'h0, f}, 32'h0);
		poke(1);
		chk("gated port", {22'h0, f}, 32'h2);
		poke(8);
		chk("gated mac", {22'h0, f}, 32'h100);
		apb(1'b0, SCG_OFF_IRQ_STATUS, 32'h0);
		chk("fault status", r, 32'h3);
		chk("irq raised", {31'h0, irq}, 32'h1);
		apb(1'b1, SCG_OFF_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, SCG_OFF_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		apb(1'b1, SCG_OFF_IRQ_CLEAR, 32'h3);
		repeat (2) @(posedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("test fault done");
	endtask
	task automatic t_unmapped();
		apb(1'b1, 12'h300, 32'hFFFFFFFF);
		chk("unmapped write err", {31'h0, e}, 32'h1);
		apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
		chk("gate kept", r, 32'h40000005);
		chk("mapped err", {31'h0, e}, 32'h0);
		apb(1'b0, 12'h304, 32'h0);
		chk("unmapped read err", {31'h0, e}, 32'h1);
		apb(1'b0, SCG_OFF_MODE_CTRL, 32'h0);
		chk("mode readback", r, 32'h3);
		apb(1'b0, SCG_OFF_IRQ_ENABLE, 32'h0);
		chk("enable readback", r, 32'h1);
		apb(1'b0, SCG_OFF_IRQ_CLEAR, 32'h0);
		chk("clear reads zero", r, 32'h0);
		$display("test unmapped done");
	endtask
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		apb(1'b1, SCG_OFF_SLEEP_GATE, 32'h00000000);
		poke(1);
		chk("frozen fault", {22'h0, f}, 32'h0);
		@(posedge clk);
		ce <= 1'b1;
		apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
		chk("frozen gate", r, 32'h40000005);
		chk("frozen enables", {22'h0, en}, 32'h205);
		$display("test freeze done");
	endtask
	task automatic t_midreset();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk("enables after reset", {22'h0, en}, 32'h3FF);
		apb(1'b0, SCG_OFF_SLEEP_GATE, 32'h0);
		chk("gate after reset", r, 32'h00000000);
		apb(1'b0, SCG_OFF_MODE_CTRL, 32'h0);
		chk("mode after reset", r, 32'h0);
		$display("test midreset done");
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_fields();
		t_gate();
		t_fault();
		t_freeze();
		t_unmapped();
		t_midreset();
		give_verdict();
	end
endmodule
`default_nettype wire
